// ===== core/ocd_divider.sv
`include "ocd_regs.svh"
`default_nettype none
module ocd_divider
	import ocd_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// register port from the serial control port
	input wire ocd_reg_req_t REG_REQ,
	output logic [7:0] REG_RDATA,
	// chip-level alignment pulse, active high
	input wire logic ALIGN_PULSE,
	// channel 0 and 1 output pairs
	output var ocd_pins_t [1:0] CLK_OUT_PAIR_A,
	output var ocd_pins_t [1:0] CLK_OUT_PAIR_B,
	output var ocd_pins_t [1:0] CLK_OUT_PAIR_C
);

	// length of one phase in input cycles, minus one; duty fix splits the
	// period evenly so the ratio is kept while the duty cycle nears 50 %
	function automatic logic [4:0] phase_len_m1(input logic [7:0] lens,
			input logic level, input logic duty_fix);
		logic [5:0] total;
		logic [5:0] lo_even;
		logic [5:0] hi_even;
		total = 6'(lens[`OCD_LOW_MSB:`OCD_LOW_LSB])
			+ 6'(lens[`OCD_HIGH_MSB:`OCD_HIGH_LSB]) + 6'h02;
		lo_even = total >> 1;
		hi_even = total - lo_even;
		if (duty_fix) begin
			phase_len_m1 = level ? 5'(hi_even - 6'h01)
				: 5'(lo_even - 6'h01);
		end else if (level) begin
			phase_len_m1 = {1'b0, lens[`OCD_HIGH_MSB:`OCD_HIGH_LSB]};
		end else begin
			phase_len_m1 = {1'b0, lens[`OCD_LOW_MSB:`OCD_LOW_LSB]};
		end
	endfunction : phase_len_m1

	logic [7:0] phase_reg [2];
	logic [7:0] ctrl_reg [2];
	logic [7:0] pwr0;
	logic [7:0] pwr_eff [2];
	logic [7:0] next_rdata;
	logic [4:0] cnt [2];
	logic [4:0] next_cnt [2];
	logic lvl [2];
	logic next_lvl [2];
	ocd_state_t state [2];
	ocd_state_t next_state [2];
	logic out_p [2];
	logic out_n [2];
	logic out_oe [2];

	wire logic wr_div0_phase = REG_REQ.wr
		&& REG_REQ.addr == `OCD_ADDR_DIV0_PHASE;
	wire logic wr_div0_ctrl = REG_REQ.wr
		&& REG_REQ.addr == `OCD_ADDR_DIV0_CTRL;
	wire logic wr_ch0_pwr = REG_REQ.wr && REG_REQ.addr == `OCD_ADDR_CH0_PWR;
	wire logic wr_div1_phase = REG_REQ.wr
		&& REG_REQ.addr == `OCD_ADDR_DIV1_PHASE;
	wire logic wr_div1_ctrl = REG_REQ.wr
		&& REG_REQ.addr == `OCD_ADDR_DIV1_CTRL;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			phase_reg[0] <= `OCD_RST_DIV0_PHASE;
			phase_reg[1] <= `OCD_RST_DIV1_PHASE;
			ctrl_reg[0] <= `OCD_RST_CTRL;
			ctrl_reg[1] <= `OCD_RST_CTRL;
			pwr0 <= `OCD_RST_PWR;
		end else begin
			if (wr_div0_phase) phase_reg[0] <= REG_REQ.wdata;
			if (wr_div1_phase) phase_reg[1] <= REG_REQ.wdata;
			if (wr_div0_ctrl) ctrl_reg[0] <= REG_REQ.wdata;
			if (wr_div1_ctrl) ctrl_reg[1] <= REG_REQ.wdata;
			if (wr_ch0_pwr) pwr0 <= REG_REQ.wdata & `OCD_PWR_MASK;
		end
	end

	// channel 1 power register sits outside this block, so it runs powered
	// up with duty fix on
	assign pwr_eff[0] = pwr0;
	assign pwr_eff[1] = `OCD_RST_PWR;

	assign next_rdata =
		REG_REQ.addr == `OCD_ADDR_DIV0_PHASE ? phase_reg[0] :
		REG_REQ.addr == `OCD_ADDR_DIV0_CTRL ? ctrl_reg[0] :
		REG_REQ.addr == `OCD_ADDR_CH0_PWR ? pwr0 :
		REG_REQ.addr == `OCD_ADDR_DIV1_PHASE ? phase_reg[1] :
		REG_REQ.addr == `OCD_ADDR_DIV1_CTRL ? ctrl_reg[1] : 8'h00;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			REG_RDATA <= 8'h00;
		end else begin
			REG_RDATA <= next_rdata;
		end
	end

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		wire logic bypass = ctrl_reg[ch][`OCD_BYPASS_BIT];
		wire logic ignore = ctrl_reg[ch][`OCD_IGNORE_BIT];
		wire logic force_hi = ctrl_reg[ch][`OCD_FORCE_BIT];
		wire logic start_hi = ctrl_reg[ch][`OCD_START_BIT];
		wire logic [3:0] offset =
			ctrl_reg[ch][`OCD_OFFSET_MSB:`OCD_OFFSET_LSB];
		wire logic duty_fix = !pwr_eff[ch][`OCD_DUTY_FIX_OFF_BIT];
		wire logic pd = pwr_eff[ch][`OCD_PD_BIT];
		wire logic obey = ALIGN_PULSE && !ignore;
		wire logic [4:0] start_len =
			phase_len_m1(phase_reg[ch], start_hi, duty_fix);
		wire logic [4:0] flip_len =
			phase_len_m1(phase_reg[ch], !lvl[ch], duty_fix);
		// offset cycles are spent at the start level ahead of its own phase
		wire logic [4:0] align_len = start_len + {1'b0, offset};

		always_comb begin
			next_state[ch] = state[ch];
			next_cnt[ch] = cnt[ch];
			next_lvl[ch] = lvl[ch];
			if (bypass) begin
				next_state[ch] = OCD_ST_HOLD;
				next_lvl[ch] = !lvl[ch];
			end else if (ignore) begin
				next_state[ch] = OCD_ST_HOLD;
				next_lvl[ch] = force_hi;
			end else if (obey) begin
				next_state[ch] = OCD_ST_RUN;
				next_lvl[ch] = start_hi;
				next_cnt[ch] = align_len;
			end else begin
				unique case (state[ch])
					OCD_ST_HOLD: begin
						next_state[ch] = OCD_ST_RUN;
						next_lvl[ch] = start_hi;
						next_cnt[ch] = start_len;
					end
					OCD_ST_RUN: begin
						if (cnt[ch] == 5'h00) begin
							next_lvl[ch] = !lvl[ch];
							next_cnt[ch] = flip_len;
						end else begin
							next_cnt[ch] = cnt[ch] - 5'h01;
						end
					end
				endcase
			end
		end

		always_ff @(posedge CLK_SYS or negedge RST_B) begin
			if (!RST_B) begin
				state[ch] <= OCD_ST_HOLD;
				cnt[ch] <= 5'h00;
				lvl[ch] <= 1'b0;
			end else begin
				state[ch] <= next_state[ch];
				cnt[ch] <= next_cnt[ch];
				lvl[ch] <= next_lvl[ch];
			end
		end

		// the pads are driven from their own flops so power-down lands on
		// the same edge for all three pairs
		always_ff @(posedge CLK_SYS or negedge RST_B) begin
			if (!RST_B) begin
				out_p[ch] <= 1'b0;
				out_n[ch] <= 1'b0;
				out_oe[ch] <= 1'b0;
			end else begin
				out_p[ch] <= !pd && next_lvl[ch];
				out_n[ch] <= !pd && !next_lvl[ch];
				out_oe[ch] <= !pd;
			end
		end

		assign CLK_OUT_PAIR_A[ch] = '{p: out_p[ch], n: out_n[ch],
			oe: out_oe[ch]};
		assign CLK_OUT_PAIR_B[ch] = '{p: out_p[ch], n: out_n[ch],
			oe: out_oe[ch]};
		assign CLK_OUT_PAIR_C[ch] = '{p: out_p[ch], n: out_n[ch],
			oe: out_oe[ch]};
	end

endmodule : ocd_divider
`default_nettype wire

// ===== core/ocd_regs.svh
`ifndef OCD_REGS_SVH
`define OCD_REGS_SVH

`define OCD_ADDR_DIV0_PHASE 10'h190
`define OCD_ADDR_DIV0_CTRL 10'h191
`define OCD_ADDR_CH0_PWR 10'h192
`define OCD_ADDR_DIV1_PHASE 10'h193
`define OCD_ADDR_DIV1_CTRL 10'h194

`define OCD_RST_DIV0_PHASE 8'h77
`define OCD_RST_DIV1_PHASE 8'h33
`define OCD_RST_CTRL 8'h00
`define OCD_RST_PWR 8'h00
`define OCD_PWR_MASK 8'h05

`define OCD_LOW_MSB 7
`define OCD_LOW_LSB 4
`define OCD_HIGH_MSB 3
`define OCD_HIGH_LSB 0
`define OCD_BYPASS_BIT 7
`define OCD_IGNORE_BIT 6
`define OCD_FORCE_BIT 5
`define OCD_START_BIT 4
`define OCD_OFFSET_MSB 3
`define OCD_OFFSET_LSB 0
`define OCD_PD_BIT 2
`define OCD_DUTY_FIX_OFF_BIT 0

`endif

// ===== core/ocd_pkg.sv
`default_nettype none
package ocd_pkg;
	typedef struct packed {
		logic p;
		logic n;
		logic oe;
	} ocd_pins_t;

	typedef struct packed {
		logic [9:0] addr;
		logic wr;
		logic [7:0] wdata;
	} ocd_reg_req_t;

	typedef enum logic [1:0] {
		OCD_ST_HOLD = 2'b01,
		OCD_ST_RUN = 2'b10
	} ocd_state_t;
endpackage : ocd_pkg
`default_nettype wire

// ===== dv/ocd_sink.sv
`default_nettype none
// receiving clocked device: measures the last high and low run of p
module ocd_sink
	import ocd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// observed pair and measured runs
	input wire ocd_pins_t pin,
	output logic [7:0] hi_len,
	output logic [7:0] lo_len
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] run;
	logic last;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{run, last, hi_len, lo_len} <= '0;
		end else begin
			last <= pin.p;
			run <= (pin.p != last) ? 8'h01 : run + 8'h01;
			if (pin.p != last && last)
				hi_len <= run;
			if (pin.p != last && !last)
				lo_len <= run;
		end
	end
endmodule : ocd_sink
`default_nettype wire

// ===== dv/ocd_monitor.sv
`default_nettype none
module ocd_monitor
	import ocd_pkg::*;
(
	// watched ports of the divider
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire ocd_reg_req_t REG_REQ,
	input wire logic [7:0] REG_RDATA,
	input wire logic ALIGN_PULSE,
	input wire ocd_pins_t [1:0] CLK_OUT_PAIR_A,
	input wire ocd_pins_t [1:0] CLK_OUT_PAIR_B,
	input wire ocd_pins_t [1:0] CLK_OUT_PAIR_C
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	wire ocd_pins_t o0 = CLK_OUT_PAIR_A[0];
	wire ocd_pins_t o1 = CLK_OUT_PAIR_A[1];
	wire w4 = REG_REQ.wr && REG_REQ.addr == 10'h194;
	wire [7:0] wd = REG_REQ.wdata;
	logic [7:0] ph1, ct1;
	// mirror of divider 1 setup so the alignment check stays exact
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			{ph1, ct1} <= 16'h3300;
		end else begin
			if (w4)
				ct1 <= wd;
			if (REG_REQ.wr && REG_REQ.addr == 10'h193)
				ph1 <= wd;
		end
	end
	sequence s_low4; !o1.p [*4]; endsequence
	sequence s_tog4; (o1.p != $past(o1.p)) [*4]; endsequence
	property p_pairs;
		CLK_OUT_PAIR_A == CLK_OUT_PAIR_B && CLK_OUT_PAIR_B == CLK_OUT_PAIR_C;
	endproperty
	property p_diff; (o0.oe -> o0.n != o0.p) && (o1.oe -> o1.n != o1.p); endproperty
	property p_pd;
		REG_REQ.wr && REG_REQ.addr == 10'h192 && wd[2] |-> ##[1:3] !o0.oe;
	endproperty
	property p_ch1_on; $past(RST_B) |-> o1.oe; endproperty
	property p_byp; w4 && wd[7] |-> ##3 s_tog4; endproperty
	property p_force; w4 && wd[7:5] == 3'b011 |-> ##3 o1.p [*4]; endproperty
	property p_low; w4 && wd[7:5] == 3'b010 |-> ##3 s_low4; endproperty
	property p_align;
		ALIGN_PULSE && ct1 == 8'h00 && ph1 == 8'h33 |=> s_low4 ##1 o1.p;
	endproperty
	a_pairs: assert property (p_pairs) else $error("pairs differ");
	a_diff: assert property (p_diff) else $error("n not inverse");
	a_pd: assert property (p_pd) else $error("no power-down");
	a_ch1_on: assert property (p_ch1_on) else $error("ch1 off");
	a_byp: assert property (p_byp) else $error("no bypass");
	a_force: assert property (p_force) else $error("no force high");
	a_low: assert property (p_low) else $error("no force low");
	a_align: assert property (p_align) else $error("bad restart");
endmodule : ocd_monitor
bind ocd_divider ocd_monitor i_mon (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
	.REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .ALIGN_PULSE(ALIGN_PULSE),
	.CLK_OUT_PAIR_A(CLK_OUT_PAIR_A), .CLK_OUT_PAIR_B(CLK_OUT_PAIR_B),
	.CLK_OUT_PAIR_C(CLK_OUT_PAIR_C));
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
module tb_top
	import ocd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [9:0] a;
		logic [7:0] v, h, l;
		logic c;
	} ocd_row_t;
	logic clk, rst_b, align;
	ocd_reg_req_t req;
	logic [7:0] rdata;
	logic [7:0] hl [2], ll [2];
	ocd_pins_t [1:0] pa, pb, pc;
	int mismatches, n_tests;
	logic [7:0] rv [6] = '{8'h77, 8'h00, 8'h00, 8'h33, 8'h00, 8'h00};
	ocd_row_t rows [5] = '{
		'{10'h190, 8'h00, 8'h01, 8'h01, 1'b0},
		'{10'h190, 8'hFF, 8'h10, 8'h10, 1'b0},
		'{10'h190, 8'h25, 8'h06, 8'h03, 1'b0},
		'{10'h193, 8'h21, 8'h03, 8'h02, 1'b1},
		'{10'h193, 8'h33, 8'h04, 8'h04, 1'b1}};
	ocd_divider i_dut (.CLK_SYS(clk), .RST_B(rst_b), .REG_REQ(req),
		.REG_RDATA(rdata), .ALIGN_PULSE(align), .CLK_OUT_PAIR_A(pa),
		.CLK_OUT_PAIR_B(pb), .CLK_OUT_PAIR_C(pc));
	ocd_sink i_s0 (.clk(clk), .rst_b(rst_b), .pin(pa[0]), .hi_len(hl[0]),
		.lo_len(ll[0]));
	ocd_sink i_s1 (.clk(clk), .rst_b(rst_b), .pin(pa[1]), .hi_len(hl[1]),
		.lo_len(ll[1]));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{a, 1'b1, d};
		@(posedge clk) req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge clk) req.addr <= a;
		repeat (2) @(posedge clk);
		#1 chk(rdata, e);
	endtask : rd
	task automatic pulse();
		@(posedge clk) align <= 1'b1;
		@(posedge clk) align <= 1'b0;
	endtask : pulse
	task automatic close_out();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end
	initial begin
		{rst_b, align, req, mismatches, n_tests} = '0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(10'h190 + 10'(i), rv[i]);
		pulse();
		repeat (12) @(posedge clk);
		$display("reset values done");
		wr(10'h192, 8'h01);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].v);
			repeat (100) @(posedge clk);
			#1 chk(hl[rows[i].c], rows[i].h);
			chk(ll[rows[i].c], rows[i].l);
		end
		$display("ratio rows done");
		wr(10'h192, 8'hFF);
		rd(10'h192, 8'h05);
		chk(8'(pa[0].oe), 8'h00);
		chk(8'(pa[1].oe), 8'h01);
		wr(10'h192, 8'h00);
		wr(10'h194, 8'h12);
		pulse();
		#1 chk(8'(pa[1].p), 8'h01);
		repeat (5) @(posedge clk);
		#1 chk(8'(pa[1].p), 8'h01);
		@(posedge clk);
		#1 chk(8'(pa[1].p), 8'h00);
		$display("alignment done");
		wr(10'h194, 8'h60);
		repeat (8) @(posedge clk);
		#1 chk(8'(pa[1].p), 8'h01);
		wr(10'h194, 8'h40);
		pulse();
		repeat (8) @(posedge clk);
		#1 chk(8'(pa[1].p), 8'h00);
		for (int i = 0; i < 2; i++) begin
			wr(10'h194, i ? 8'hE0 : 8'h80);
			repeat (20) @(posedge clk);
			#1 chk(hl[1], 8'h01);
			chk(ll[1], 8'h01);
		end
		$display("force and bypass done");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
